// ---- ssp_pkg.sv ----
package ssp_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] ctrl_offset   = 8'h00;
    localparam logic [7:0] buf_offset    = 8'h04;
    localparam logic [7:0] status_offset = 8'h08;
    // control field positions
    localparam int collision_bit = 7;
    localparam int ov_bit        = 6;
    localparam int en_bit        = 5;
    localparam int clk_pol_bit   = 4;
    // reset values
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam logic [7:0] buf_reset  = 8'h00;
    // mode_select codes
    localparam logic [3:0] mode_spi_m_div4  = 4'h0;
    localparam logic [3:0] mode_spi_m_div16 = 4'h1;
    localparam logic [3:0] mode_spi_m_div64 = 4'h2;
    localparam logic [3:0] mode_spi_s_ss    = 4'h4;
    localparam logic [3:0] mode_spi_s_noss  = 4'h5;
    // sck half period in pclk cycles per master rate
    localparam logic [5:0] half_div4  = 6'h02;
    localparam logic [5:0] half_div16 = 6'h08;
    localparam logic [5:0] half_div64 = 6'h20;
    localparam logic [2:0] bits_last  = 3'h7;
endpackage

// ---- sync2.sv ----
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // sync2

// ---- sync_serial_port_ctrl_flags.sv ----
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
// How it works
// [RL1] slave: byte completes while buffer unread sets overflow flag
// [RL2] on overflow the new shifted byte is dropped, buffer kept
// [RL3] overflow is only raised in slave modes, never master; code also raises it in every i2c mode
// [RL4] master transfer starts only on a software buffer write
// [RL5] software must read buffer after each received byte
// [RL6] i2c: byte received while buffer unread sets overflow flag
// [RL7] overflow only cleared by software; ignored in i2c transmit
// [RL8] enable set gives sck, data out and data in pins to port
// [RL9] enable clear returns pins to general purpose use
// [RL10] i2c: enable set assigns data and clock pins to port
// [RL11] software sets pin directions correctly when enabling
// [RL12] buffer write during transmission sets write collision flag; code sets it only in master transfers, a slave is never busy
// [RL13] i2c: enable clear releases data and clock pins
module sync_serial_port_ctrl_flags (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // spi pins
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    input  wire logic        serial_data_in_pin,
    output logic             serial_data_out_pin,
    output logic             data_out_oe,
    // i2c byte event from the i2c engine, same clock
    input  wire logic        i2c_byte_done,
    input  wire logic [7:0]  i2c_byte,
    // pin ownership
    output logic             spi_pins_owned,
    output logic             i2c_pins_owned
);
    logic [7:0] ctrl_q;
    logic [7:0] buf_q;
    logic       buf_full_q;
    logic [7:0] sr_q;
    logic [2:0] bit_cnt_q;
    logic [5:0] div_q;
    logic       sck_q;
    logic       sck_prev_q;
    logic       din_q;
    logic       sck_s;
    logic       din_s;

    typedef enum logic [2:0] {
        st_idle  = 3'b001,
        st_lead  = 3'b010,
        st_trail = 3'b100
    } spi_state_e;
    spi_state_e state_q;

    sync2 #(.W(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({sck_in, serial_data_in_pin}),
        .q       ({sck_s, din_s})
    );

    // decode
    wire        access   = psel & penable;
    wire        wr       = access & pwrite;
    wire        rd       = access & ~pwrite;
    wire        hit_ctrl = paddr == ssp_pkg::ctrl_offset;
    wire        hit_buf  = paddr == ssp_pkg::buf_offset;
    wire        hit_stat = paddr == ssp_pkg::status_offset;
    wire        mapped   = hit_ctrl | hit_buf | hit_stat;
    wire        enabled  = ctrl_q[ssp_pkg::en_bit];
    wire [3:0]  mode     = ctrl_q[3:0];
    wire        clk_idle = ctrl_q[ssp_pkg::clk_pol_bit];
    wire        is_slave = (mode == ssp_pkg::mode_spi_s_ss) |
                           (mode == ssp_pkg::mode_spi_s_noss);
    wire        is_mstr  = (mode == ssp_pkg::mode_spi_m_div4) |
                           (mode == ssp_pkg::mode_spi_m_div16) |
                           (mode == ssp_pkg::mode_spi_m_div64);
    wire        is_spi   = is_slave | is_mstr;
    wire        is_i2c   = ~is_spi;
    wire        buf_wr   = wr & hit_buf;
    wire        buf_rd   = rd & hit_buf;
    wire        busy     = state_q != st_idle;
    wire [5:0]  half     = (mode == ssp_pkg::mode_spi_m_div4)
                           ? ssp_pkg::half_div4
                           : (mode == ssp_pkg::mode_spi_m_div16)
                           ? ssp_pkg::half_div16 : ssp_pkg::half_div64;
    wire        div_end  = div_q == half - 6'h01;
    // slave edges seen on synchronised sck, relative to idle level
    wire        s_lead   = (sck_s != sck_prev_q) & (sck_s != clk_idle);
    wire        s_trail  = (sck_s != sck_prev_q) & (sck_s == clk_idle);
    wire        m_lead   = (state_q == st_lead) & div_end;
    wire        m_trail  = (state_q == st_trail) & div_end;
    wire        sample   = enabled & (is_slave ? s_lead : m_lead);
    wire        shift    = enabled & (is_slave ? s_trail : m_trail);
    wire        spi_done = shift & (bit_cnt_q == ssp_pkg::bits_last);
    wire [7:0]  sr_next  = {sr_q[6:0], din_q};
    // i2c buffer only fed while enabled in an i2c mode
    wire        i2c_done = enabled & is_i2c & i2c_byte_done;
    wire        rx_done  = (spi_done & is_spi) | i2c_done;
    wire [7:0]  rx_byte  = i2c_done ? i2c_byte : sr_next;
    // [RL1] [RL3] [RL6] unread buffer overflow, never in master
    wire        ov_set   = rx_done & buf_full_q & (is_slave | is_i2c);
    // [RL12] collision on busy write
    wire        coll_set = buf_wr & enabled & busy & is_spi;
    // busy covers master transfers only; a slave never leaves st_idle
    wire        start    = buf_wr & enabled & is_mstr & ~busy;

    // control register, flags set beats software clear
    logic [7:0] ctrl_d;
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr & hit_ctrl) begin
            ctrl_d = pwdata[7:0];
        end
        // [RL7] only software clears overflow
        if (ov_set) begin
            ctrl_d[ssp_pkg::ov_bit] = 1'b1;
        end
        if (coll_set) begin
            ctrl_d[ssp_pkg::collision_bit] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ssp_pkg::ctrl_reset;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // receive buffer and transmit load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_q      <= ssp_pkg::buf_reset;
            buf_full_q <= 1'b0;
        end else begin
            // [RL2] overflow drops new byte
            if (rx_done & ~buf_full_q) begin
                buf_q      <= rx_byte;
                buf_full_q <= 1'b1;
            end else if (buf_rd) begin
                buf_full_q <= 1'b0;
            end
            // a write replaces the buffer only when it may load
            if (buf_wr & ~busy & ~rx_done) begin
                buf_q <= pwdata[7:0];
            end
        end
    end

    // shifter and master clock generator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q    <= st_idle;
            sr_q       <= 8'h00;
            bit_cnt_q  <= 3'h0;
            div_q      <= 6'h00;
            sck_q      <= 1'b0;
            sck_prev_q <= 1'b0;
            din_q      <= 1'b0;
        end else begin
            sck_prev_q <= sck_s;
            div_q      <= (busy & ~div_end) ? div_q + 6'h01 : 6'h00;
            if (!enabled) begin
                state_q   <= st_idle;
                bit_cnt_q <= 3'h0;
                sck_q     <= clk_idle;
            end else if (start | (buf_wr & is_slave & ~busy)) begin
                // [RL4] master starts on buffer write
                sr_q      <= pwdata[7:0];
                bit_cnt_q <= 3'h0;
                state_q   <= is_mstr ? st_lead : st_idle;
            end else begin
                if (sample) begin
                    din_q <= din_s;
                    if (is_mstr) begin
                        state_q <= st_trail;
                        sck_q   <= ~clk_idle;
                    end
                end
                if (shift) begin
                    sr_q      <= sr_next;
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                    if (is_mstr) begin
                        sck_q   <= clk_idle;
                        state_q <= spi_done ? st_idle : st_lead;
                    end
                end
            end
        end
    end

    // pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_out             <= 1'b0;
            sck_oe              <= 1'b0;
            serial_data_out_pin <= 1'b0;
            data_out_oe         <= 1'b0;
            spi_pins_owned      <= 1'b0;
            i2c_pins_owned      <= 1'b0;
        end else begin
            sck_out             <= sck_q;
            // [RL8] [RL9] spi pin handover
            spi_pins_owned      <= enabled & is_spi;
            sck_oe              <= enabled & is_mstr;
            data_out_oe         <= enabled & is_spi;
            serial_data_out_pin <= sr_q[7];
            // [RL10] [RL13] i2c pin handover
            i2c_pins_owned      <= enabled & is_i2c;
        end
    end

    // apb answer, zero wait states
    wire [31:0] rdata_d = hit_ctrl ? {24'h000000, ctrl_q}
                        : hit_buf  ? {24'h000000, buf_q}
                        : hit_stat ? {30'h00000000, busy, buf_full_q}
                        : 32'h00000000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h00000000;
        end
    end
endmodule // sync_serial_port_ctrl_flags

// ---- ssp_flags_monitor.sv ----
`timescale 1ns/10ps
module ssp_flags_monitor (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // pins
    input wire logic        sck_out,
    input wire logic        sck_oe,
    input wire logic        data_out_oe,
    input wire logic        spi_pins_owned,
    input wire logic        i2c_pins_owned
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] ctl_q;
    logic [1:0] seen_q;
    logic [9:0] idle_q;
    wire       acc     = psel & penable & pready;
    wire       cw      = acc & pwrite & (paddr == ssp_pkg::ctrl_offset);
    wire       cr      = acc & ~pwrite & (paddr == ssp_pkg::ctrl_offset);
    wire       bw      = acc & pwrite & (paddr == ssp_pkg::buf_offset);
    wire [3:0] wm      = pwdata[3:0];
    wire       spi_cfg = wm < 4'h3 || wm[3:1] == 3'h2;
    wire       mst     = ctl_q[5] & (ctl_q[3:0] < 4'h3);
    // shadow of control writes; flags seen set stay set until a control write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q  <= ssp_pkg::ctrl_reset;
            seen_q <= 2'h0;
            idle_q <= 10'h000;
        end else begin
            if (cw) ctl_q <= pwdata[7:0];
            seen_q <= cw ? 2'h0 : seen_q | ({2{cr}} & prdata[7:6]);
            idle_q <= (bw | cw) ? 10'h000 : idle_q + {9'h000, ~&idle_q};
        end
    end
    chk_en_owns: assert property (
        cw && pwdata[5] && spi_cfg |-> ##[1:2] spi_pins_owned)
        else $error("spi pins not taken on enable");
    chk_i2c_owns: assert property (
        cw && pwdata[5] && !spi_cfg
        |-> ##[1:2] i2c_pins_owned && !spi_pins_owned)
        else $error("i2c pins not taken on enable");
    chk_off_frees: assert property (
        cw && !pwdata[5] |-> ##[1:2] !(spi_pins_owned || i2c_pins_owned))
        else $error("pins kept after disable");
    chk_pins_quiet: assert property (
        !spi_pins_owned && !$past(spi_pins_owned) |-> !sck_oe && !data_out_oe)
        else $error("pin driven while not owned");
    // div64 byte takes 512 cycles, so 600 leaves latency slack
    chk_sck_started: assert property (
        $changed(sck_out) && mst |-> idle_q < 10'h258)
        else $error("master clock without buffer write");
    chk_ov_master: assert property (
        cr && mst && !ctl_q[6] |-> !prdata[6])
        else $error("overflow set in master mode");
    chk_ov_sticky: assert property (
        cr && seen_q[0] |-> prdata[6])
        else $error("overflow cleared by hardware");
    chk_collision_sticky: assert property (
        cr && seen_q[1] |-> prdata[7])
        else $error("collision cleared by hardware");
endmodule // ssp_flags_monitor
bind sync_serial_port_ctrl_flags ssp_flags_monitor u_mon (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .sck_out,
    .sck_oe, .data_out_oe, .spi_pins_owned, .i2c_pins_owned);

// ---- spi_far_master.sv ----
`timescale 1ns/10ps
module spi_far_master (
    // clock
    input wire logic pclk,
    // pins towards the port
    output logic     sck,
    output logic     din
);
    initial begin
        sck = 1'b0;
        din = 1'b0;
    end
    // data changes with the falling edge and is held around the rising edge, so sample on the rising edge
    task automatic send(input logic [7:0] b, input int h);
        for (int i = 7; i >= 0; i--) begin
            din <= b[i];
            repeat (h) @(posedge pclk);
            sck <= 1'b1;
            repeat (h) @(posedge pclk);
            sck <= 1'b0;
        end
        repeat (h) @(posedge pclk);
        // drive the inverse of the last bit: no stale level
        din <= ~b[0];
    endtask
endmodule // spi_far_master

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
    localparam logic [7:0] ca = ssp_pkg::ctrl_offset;
    localparam logic [7:0] ba = ssp_pkg::buf_offset;
    localparam logic [7:0] sa = ssp_pkg::status_offset;
    logic        pclk, presetn, psel, penable, pwrite, sck, din, serr;
    logic        pready, pslverr, sck_out, sck_oe, dout, data_out_oe, so, io;
    logic        i2c_byte_done;
    logic [7:0]  paddr, i2c_byte;
    logic [31:0] pwdata, prdata, r;
    int          err_total, num_checks, cyc;
    sync_serial_port_ctrl_flags u_sync_serial_port_ctrl_flags (.pclk,
        .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sck_in(sck), .sck_out, .sck_oe,
        .serial_data_in_pin(din), .serial_data_out_pin(dout), .data_out_oe,
        .i2c_byte_done, .i2c_byte, .spi_pins_owned(so), .i2c_pins_owned(io));
    spi_far_master u_spi_far_master (.pclk, .sck, .din);
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 10000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic check(input logic [31:0] g, e, input string m);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // a missing answer counts against the run
        if (pready !== 1'b1) begin
            err_total++;
            $display("Error %0t: no pready", $time);
        end
        r = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_own();
        logic [3:0] md [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
        apb(1'b0, ca, 32'h0);
        check(r, {24'h0, ssp_pkg::ctrl_reset}, "ctrl reset");
        apb(1'b0, 8'h0c, 32'h0);
        check(serr, 1'b1, "unmapped error");
        check(r, 32'h0, "unmapped data");
        foreach (md[i]) begin
            apb(1'b1, ca, {26'h0, 2'h2, md[i]});
            repeat (2) @(posedge pclk);
            check({io, so}, md[i] < 4'h6 ? 2'h1 : 2'h2, "own");
        end
        apb(1'b1, ca, 32'h0);
        repeat (2) @(posedge pclk);
        check({io, so, sck_oe, data_out_oe}, 4'h0, "freed");
        $display("test own done");
    endtask
    task automatic t_master();
        int n;
        logic s;
        apb(1'b1, ca, 32'h20);
        s = sck_out;
        repeat (20) @(posedge pclk);
        check(sck_out, s, "idle clock");
        check({sck_oe, data_out_oe}, 2'h3, "master pins");
        apb(1'b1, ba, 32'ha5);
        // first leading clock edge carries the msb of the byte
        n = 0;
        while (sck_out === s && n < 20) begin
            @(posedge pclk);
            n++;
        end
        check({sck_out, dout}, 2'h3, "first bit");
        apb(1'b1, ba, 32'h5a);
        apb(1'b0, ca, 32'h0);
        check(r[7], 1'b1, "collision");
        // second byte ends on a full buffer: master must not overflow
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                apb(1'b0, sa, 32'h0);
                n++;
            end while (r[1] !== 1'b0 && n < 60);
            check(r[1], 1'b0, "busy ends");
            if (k == 0) apb(1'b1, ba, 32'h3c);
        end
        apb(1'b0, ca, 32'h0);
        check(r[7:6], 2'h2, "master flags");
        // empty the buffer so the slave bytes land
        apb(1'b0, ba, 32'h0);
        apb(1'b1, ca, 32'h20);
        apb(1'b0, ca, 32'h0);
        check(r[7:0], 8'h20, "flags cleared");
        $display("test master done");
    endtask
    task automatic t_slave();
        apb(1'b1, ca, 32'h25);
        u_spi_far_master.send(8'h81, 8);
        apb(1'b0, ba, 32'h0);
        check(r[7:0], 8'h81, "slave byte");
        u_spi_far_master.send(8'h96, 8);
        apb(1'b0, ca, 32'h0);
        check(r[6], 1'b0, "no overflow");
        u_spi_far_master.send(8'h3c, 20);
        apb(1'b0, ca, 32'h0);
        check(r[6], 1'b1, "overflow");
        apb(1'b0, ba, 32'h0);
        check(r[7:0], 8'h96, "buffer kept");
        apb(1'b0, ca, 32'h0);
        check(r[6], 1'b1, "still set");
        apb(1'b1, ca, 32'h25);
        apb(1'b0, ca, 32'h0);
        check(r[6], 1'b0, "sw clear");
        $display("test slave done");
    endtask
    task automatic i2c_put(input logic [7:0] b);
        i2c_byte <= b;
        i2c_byte_done <= 1'b1;
        @(posedge pclk);
        i2c_byte_done <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_i2c();
        apb(1'b1, ca, 32'h26);
        i2c_put(8'h3c);
        i2c_put(8'hc3);
        apb(1'b0, ca, 32'h0);
        check(r[6], 1'b1, "i2c overflow");
        apb(1'b0, ba, 32'h0);
        check(r[7:0], 8'h3c, "i2c buffer");
        $display("test i2c done");
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {pclk, presetn, psel, penable, pwrite, i2c_byte_done} = 6'h00;
        {paddr, i2c_byte, pwdata} = 48'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_own();
        t_master();
        t_slave();
        t_i2c();
        stop_test();
    end
endmodule // testbench
